// ---- sfx_pkg.sv ----
// Shared constants and types for the serial flash host controller
package sfx_pkg;

  // Register byte offsets on the Wishbone side
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_LEN  = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam int unsigned BUF_SEL_BIT = 10;

  // Field positions
  localparam int unsigned CTRL_DUAL_BIT   = 8;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_INIT_BIT   = 1;
  localparam int unsigned STAT_CONT_BIT   = 2;
  localparam int unsigned STAT_REFUSE_BIT = 3;

  // Host commands written to the control register
  localparam logic [3:0] CMD_RST    = 4'h0;
  localparam logic [3:0] CMD_WRAP   = 4'h1;
  localparam logic [3:0] CMD_WORD   = 4'h2;
  localparam logic [3:0] CMD_OCTAL  = 4'h3;
  localparam logic [3:0] CMD_PROG   = 4'h4;
  localparam logic [3:0] CMD_WREN   = 4'h5;
  localparam logic [3:0] CMD_STATUS = 4'h6;
  localparam logic [3:0] CMD_PERF   = 4'h7;

  // Opcodes on the link
  localparam logic [7:0] OP_WRAP   = 8'h77;
  localparam logic [7:0] OP_WORD   = 8'he7;
  localparam logic [7:0] OP_OCTAL  = 8'he3;
  localparam logic [7:0] OP_PROG   = 8'h02;
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [7:0] OP_PERF   = 8'ha3;

  // Link clock counts per segment
  localparam logic [4:0] CLK_OPC       = 5'd8;
  localparam logic [4:0] CLK_RST_QUAD  = 5'd8;
  localparam logic [4:0] CLK_RST_DUAL  = 5'd16;
  localparam logic [4:0] CLK_ADDR_1    = 5'd24;
  localparam logic [4:0] CLK_ADDR_4    = 5'd6;
  localparam logic [4:0] CLK_BYTE_4    = 5'd2;
  localparam logic [4:0] CLK_BYTE_1    = 5'd8;
  localparam logic [4:0] CLK_DUMMY_WRD = 5'd2;

  // Address masks, values after reset, continuous mode select and last init step
  localparam logic [23:0] MASK_WORD   = 24'hfffffe;
  localparam logic [23:0] MASK_OCTAL  = 24'hfffff0;
  localparam logic [7:0]  WRAP_OFF    = 8'h10;
  localparam logic [8:0]  LEN_RESET   = 9'h001;
  localparam logic [1:0]  CONT_SELECT = 2'b10;
  localparam logic [1:0]  INIT_LAST   = 2'h2;

  // Link timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SCK_HALF_NS   = 20;
  localparam int unsigned SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [8:0] {
    S_IDLE  = 9'b000000001,
    S_START = 9'b000000010,
    S_OPC   = 9'b000000100,
    S_RST   = 9'b000001000,
    S_ADDR  = 9'b000010000,
    S_MODE  = 9'b000100000,
    S_DUMMY = 9'b001000000,
    S_RD    = 9'b010000000,
    S_WR    = 9'b100000000
  } sfx_st_t;

endpackage : sfx_pkg

// ---- sfx_sync.sv ----
// Two-flop synchroniser for the link input lines
`timescale 1ns/1ps
module sfx_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sfx_sync_t;

  sfx_sync_t r_q;
  sfx_sync_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.meta = d_in;
    r_d.sync = r_q.meta;
    if (rst_in) begin
      r_d = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    r_q <= r_d;
  end

  assign q_out = r_q.sync;

endmodule : sfx_sync

// ---- sfx_xip_host.sv ----
// Host controller driving the serial flash over its SPI pins
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sfx_xip_host import sfx_pkg::*; #(
  parameter int unsigned HALF = SCK_HALF_CYC,
  parameter int unsigned AW   = 12
) (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic          wb_cyc_in,
  input  wire logic          wb_stb_in,
  input  wire logic          wb_we_in,
  input  wire logic [AW-1:0] wb_adr_in,
  input  wire logic [3:0]    wb_sel_in,
  input  wire logic [31:0]   wb_dat_in,
  output logic      [31:0]   wb_dat_out,
  output logic               wb_ack_out,
  output logic               sck_out,
  output logic               cs_n_out,
  output logic      [3:0]    io_out,
  output logic      [3:0]    io_oe_out,
  input  wire logic [3:0]    io_in
);

  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  typedef struct packed {
    sfx_st_t             st;
    sfx_st_t             first;
    logic [7:0]          div;
    logic                sck;
    logic                cs_n;
    logic [3:0]          io;
    logic [3:0]          oe;
    logic                quad;
    logic [31:0]         sh;
    logic [7:0]          rx;
    logic [4:0]          clks;
    logic [8:0]          left;
    logic [7:0]          idx;
    logic [3:0]          cmd;
    logic                dual_rst;
    logic [23:0]         addr;
    logic [7:0]          mode;
    logic [7:0]          wrap;
    logic [8:0]          len;
    logic                cont;
    logic [3:0]          cont_cmd;
    logic                refused;
    logic                init_done;
    logic [1:0]          init_step;
    logic [7:0]          stat_byte;
    logic                ack;
    logic [31:0]         dat;
    logic [255:0][7:0]   pbuf;
  } sfx_regs_t;

  sfx_regs_t r_q;
  sfx_regs_t r_d;
  logic [3:0] io_s;

  sfx_sync #(.W(4)) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     (io_in),
    .q_out    (io_s)
  );

  function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        v[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return v;
  endfunction : wmask

  function automatic logic [7:0] opcode_of(input logic [3:0] c);
    logic [7:0] op;
    op = OP_PERF;
    case (c)
      CMD_WRAP:   op = OP_WRAP;
      CMD_WORD:   op = OP_WORD;
      CMD_OCTAL:  op = OP_OCTAL;
      CMD_PROG:   op = OP_PROG;
      CMD_WREN:   op = OP_WREN;
      CMD_STATUS: op = OP_STATUS;
      default:    op = OP_PERF;
    endcase
    return op;
  endfunction : opcode_of

  function automatic sfx_st_t next_st(input logic [3:0] c,
                                      input sfx_st_t    s);
    sfx_st_t nx;
    nx = S_IDLE;
    unique case (s)
      S_OPC: begin
        if (c == CMD_STATUS) begin
          nx = S_RD;
        end else if (c == CMD_WREN || c == CMD_PERF) begin
          nx = S_IDLE;
        end else begin
          nx = S_ADDR;
        end
      end
      S_ADDR:  nx = (c == CMD_PROG) ? S_WR : S_MODE;
      S_MODE: begin
        if (c == CMD_WRAP) begin
          nx = S_IDLE;
        end else if (c == CMD_WORD) begin
          nx = S_DUMMY;
        end else begin
          nx = S_RD;
        end
      end
      S_DUMMY: nx = S_RD;
      S_RST, S_RD, S_WR, S_IDLE, S_START: nx = S_IDLE;
    endcase
    return nx;
  endfunction : next_st

  // Loads a segment; S_IDLE here means end of frame with select raised
  function automatic sfx_regs_t enter(input sfx_regs_t s_in,
                                      input sfx_st_t   nx);
    sfx_regs_t s;
    s = s_in;
    s.st = nx;
    s.div = '0;
    s.sh = '0;
    unique case (nx)
      S_OPC: begin
        s.sh = {opcode_of(s.cmd), 24'h0};
        s.quad = 1'b0;
        s.clks = CLK_OPC;
        s.oe = 4'b1101;
      end
      S_RST: begin
        s.sh = '1;
        s.quad = 1'b1;
        s.clks = s.dual_rst ? CLK_RST_DUAL : CLK_RST_QUAD;
        s.oe = 4'b1111;
      end
      S_ADDR: begin
        s.quad = (s.cmd != CMD_PROG);
        s.oe = s.quad ? 4'b1111 : 4'b1101;
        s.clks = s.quad ? CLK_ADDR_4 : CLK_ADDR_1;
        if (s.cmd == CMD_PROG) begin
          s.sh = {s.addr, 8'h0};
        end else if (s.cmd == CMD_WRAP) begin
          s.sh = {24'hffffff, 8'h0};
        end else if (s.cmd == CMD_WORD) begin
          s.sh = {s.addr & MASK_WORD, 8'h0};
        end else begin
          s.sh = {s.addr & MASK_OCTAL, 8'h0};
        end
      end
      S_MODE: begin
        s.sh = {(s.cmd == CMD_WRAP) ? s.wrap : s.mode, 24'h0};
        s.quad = 1'b1;
        s.clks = CLK_BYTE_4;
        s.oe = 4'b1111;
      end
      S_DUMMY: begin
        s.quad = 1'b1;
        s.clks = CLK_DUMMY_WRD;
        s.oe = 4'b0000;
      end
      S_RD: begin
        s.quad = (s.cmd != CMD_STATUS);
        s.clks = s.quad ? CLK_BYTE_4 : CLK_BYTE_1;
        s.oe = s.quad ? 4'b0000 : 4'b1101;
      end
      S_WR: begin
        s.sh = {s.pbuf[s.idx], 24'h0};
        s.quad = 1'b0;
        s.clks = CLK_BYTE_1;
        s.oe = 4'b1101;
      end
      S_IDLE, S_START: begin
        s.cs_n = 1'b1;
        s.oe = 4'b0000;
        s.sck = 1'b0;
      end
    endcase
    s.io = s.quad ? s.sh[31:28] : {3'b110, s.sh[31]};
    return s;
  endfunction : enter

  // Starts a frame; opcode skipped while the same read stays continuous
  function automatic sfx_regs_t issue(input sfx_regs_t s_in,
                                      input logic [3:0] c);
    sfx_regs_t s;
    logic      rd;
    s = s_in;
    rd = (c == CMD_WORD || c == CMD_OCTAL);
    s.cmd = c;
    s.st = S_START;
    s.cs_n = 1'b0;
    s.sck = 1'b0;
    s.div = '0;
    s.idx = '0;
    s.left = (c == CMD_STATUS) ? 9'h001 : s.len;
    if (c == CMD_RST) begin
      s.first = S_RST;
      s.cont = 1'b0;
    end else if (rd && s.cont && s.cont_cmd == c) begin
      s.first = S_ADDR;
    end else begin
      s.first = S_OPC;
    end
    if (rd) begin
      s.cont = (s.mode[5:4] == CONT_SELECT);
      s.cont_cmd = c;
    end
    return s;
  endfunction : issue

  always_comb begin
    logic    busy;
    logic    tick;
    logic    start;
    sfx_st_t nx;
    busy = (r_q.st != S_IDLE);
    tick = (r_q.div == HALF_M1);
    start = 1'b0;
    nx = S_IDLE;
    r_d = r_q;
    r_d.ack = 1'b0;

    if (wb_cyc_in && wb_stb_in && !r_q.ack) begin
      r_d.ack = 1'b1;
      r_d.dat = '0;
      if (wb_adr_in[BUF_SEL_BIT]) begin
        r_d.dat = {24'h0, r_q.pbuf[wb_adr_in[9:2]]};
        if (wb_we_in && wb_sel_in[0]) begin
          r_d.pbuf[wb_adr_in[9:2]] = wb_dat_in[7:0];
        end
      end else begin
        case (wb_adr_in[7:0])
          REG_CTRL: begin
            r_d.dat = {23'h0, r_q.dual_rst, 4'h0, r_q.cmd};
            if (wb_we_in && wb_sel_in[0]) begin
              if (busy || !r_q.init_done ||
                  (r_q.cont && wb_dat_in[3:0] != CMD_RST &&
                   wb_dat_in[3:0] != r_q.cont_cmd)) begin
                r_d.refused = 1'b1;
              end else begin
                start = 1'b1;
                if (wb_sel_in[1]) begin
                  r_d.dual_rst = wb_dat_in[CTRL_DUAL_BIT];
                end
              end
            end
          end
          REG_ADDR: begin
            r_d.dat = {8'h0, r_q.addr};
            if (wb_we_in) begin
              r_d.addr = 24'(wmask({8'h0, r_q.addr}, wb_dat_in, wb_sel_in));
            end
          end
          REG_MODE: begin
            r_d.dat = {16'h0, r_q.wrap, r_q.mode};
            if (wb_we_in) begin
              {r_d.wrap, r_d.mode} = 16'(wmask({16'h0, r_q.wrap, r_q.mode},
                                              wb_dat_in, wb_sel_in));
            end
          end
          REG_LEN: begin
            r_d.dat = {23'h0, r_q.len};
            if (wb_we_in) begin
              r_d.len = 9'(wmask({23'h0, r_q.len}, wb_dat_in, wb_sel_in));
            end
          end
          REG_STAT: begin
            r_d.dat = {16'h0, r_q.stat_byte, 4'h0, r_q.refused, r_q.cont,
                       r_q.init_done, busy};
            if (wb_we_in && wb_sel_in[0] && wb_dat_in[STAT_REFUSE_BIT]) begin
              r_d.refused = 1'b0;
            end
          end
          default: r_d.dat = '0;
        endcase
      end
    end

    // Refusals seen in this same cycle win over the clear
    if (wb_cyc_in && wb_stb_in && !r_q.ack && wb_we_in &&
        !wb_adr_in[BUF_SEL_BIT] && wb_adr_in[7:0] == REG_CTRL &&
        wb_sel_in[0] && !start) begin
      r_d.refused = 1'b1;
    end

    unique case (r_q.st)
      S_IDLE: begin
        if (start) begin
          r_d = issue(r_d, wb_dat_in[3:0]);
        end else if (!r_q.init_done) begin
          // Device has no reset pin, so it is put in a known state
          if (r_q.init_step == 2'h0) begin
            r_d.dual_rst = 1'b1;
            r_d = issue(r_d, CMD_RST);
          end else if (r_q.init_step == 2'h1) begin
            r_d.wrap = WRAP_OFF;
            r_d = issue(r_d, CMD_WRAP);
          end else begin
            r_d = issue(r_d, CMD_PERF);
          end
        end
      end
      S_START: begin
        r_d.div = r_q.div + 8'h01;
        if (tick) begin
          r_d = enter(r_d, r_q.first);
        end
      end
      S_OPC, S_RST, S_ADDR, S_MODE, S_DUMMY, S_RD, S_WR: begin
        r_d.div = r_q.div + 8'h01;
        if (tick) begin
          r_d.div = '0;
          r_d.sck = ~r_q.sck;
          if (!r_q.sck) begin
            r_d.rx = r_q.quad ? {r_q.rx[3:0], io_s} : {r_q.rx[6:0], io_s[1]};
            r_d.clks = r_q.clks - 5'd1;
          end else if (r_q.clks == 5'd0) begin
            // Byte boundary reached; select only rises here
            if (r_q.st == S_RD) begin
              r_d.pbuf[r_q.idx] = r_q.rx;
              if (r_q.cmd == CMD_STATUS) begin
                r_d.stat_byte = r_q.rx;
              end
            end
            if (r_q.st == S_RD || r_q.st == S_WR) begin
              r_d.idx = r_q.idx + 8'h01;
              r_d.left = r_q.left - 9'h001;
              nx = (r_q.left > 9'h001) ? r_q.st : S_IDLE;
            end else begin
              nx = next_st(r_q.cmd, r_q.st);
            end
            r_d = enter(r_d, nx);
            if (nx == S_IDLE && !r_q.init_done) begin
              r_d.init_step = r_q.init_step + 2'h1;
              r_d.init_done = (r_q.init_step == INIT_LAST);
            end
          end else begin
            // Reset pattern must stay all ones for all 8 or 16 clocks
            if (r_q.st != S_RST) begin
              r_d.sh = r_q.quad ? (r_q.sh << 4) : (r_q.sh << 1);
            end
            r_d.io = r_q.quad ? r_d.sh[31:28] : {3'b110, r_d.sh[31]};
          end
        end
      end
    endcase

    if (rst_in) begin
      r_d = '0;
      r_d.st = S_IDLE;
      r_d.first = S_OPC;
      r_d.cs_n = 1'b1;
      r_d.wrap = WRAP_OFF;
      r_d.len = LEN_RESET;
    end
  end

  always_ff @(posedge clock_in) begin
    r_q <= r_d;
  end

  assign wb_dat_out = r_q.dat;
  assign wb_ack_out = r_q.ack;
  assign sck_out    = r_q.sck;
  assign cs_n_out   = r_q.cs_n;
  assign io_out     = r_q.io;
  assign io_oe_out  = r_q.oe;

endmodule : sfx_xip_host

// ---- sfx_xip_monitor.sv ----
// Pin-level checks on the flash host controller
`timescale 1ns/1ps
module sfx_xip_monitor #(
  parameter int unsigned HALF = 4
) (
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       wb_cyc_in,
  input wire logic       wb_stb_in,
  input wire logic       wb_ack_out,
  input wire logic       sck_out,
  input wire logic       cs_n_out,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic seen_q;
  // Marks that the first frame after reset has started clocking
  always_ff @(posedge clock_in) begin
    if (rst_in) seen_q <= 1'b0;
    else if (sck_out) seen_q <= 1'b1;
  end
  sequence s_quiet;
    !sck_out [*3];
  endsequence
  sequence s_high;
    ##(HALF) $fell(sck_out);
  endsequence
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  property p_ack_answer;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  property p_ack_cause;
    $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  property p_sck_idle; cs_n_out |-> !sck_out; endproperty
  property p_cs_rise; $rose(cs_n_out) |-> $fell(sck_out); endproperty
  property p_cs_open; $fell(cs_n_out) |-> s_quiet; endproperty
  property p_sck_half; $rose(sck_out) |-> s_high; endproperty
  property p_io_steady; $changed(io_out) |-> !sck_out; endproperty
  property p_oe_release; $fell(io_oe_out[3]) |-> !sck_out; endproperty
  property p_first_frame;
    $rose(sck_out) && !seen_q |-> io_out == 4'hf && io_oe_out == 4'hf;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock outside frame");
  a_cs_rise: assert property (p_cs_rise)
    else $error("select rose off a clock fall");
  a_cs_open: assert property (p_cs_open)
    else $error("clock too soon after select");
  a_sck_half: assert property (p_sck_half)
    else $error("clock high phase wrong");
  a_io_steady: assert property (p_io_steady)
    else $error("data moved while clock high");
  a_oe_release: assert property (p_oe_release)
    else $error("lines released while clock high");
  a_first_frame: assert property (p_first_frame)
    else $error("first frame not all ones");
endmodule : sfx_xip_monitor

// ---- sfx_flash_model.sv ----
// Behavioural flash device answering the host controller
`timescale 1ns/1ps
module sfx_flash_model #(
  parameter int          TPP       = 3000,
  parameter logic [23:0] PROT_FROM = 24'hf00000,
  parameter logic        QUAD_EN   = 1'b1
) (
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] io_in,
  input  wire logic [3:0] oe_in,
  output logic      [3:0] io_out
);
  logic [7:0]  mem [0:1023];
  logic [31:0] pq [$];
  logic [3:0]  drv, dout;
  logic [2:0]  wrap;
  logic [7:0]  cont_op, op;
  logic        wr_latch, busy, perf_mode, cont;
  int          err = 0;
  int          clks;
  // Released lines show the inverse of the last level, not a stale copy
  assign io_out = (oe_in & io_in) | (~oe_in & drv & dout) |
                  (~oe_in & ~drv & ~io_in);
  always @(posedge sck_in or negedge cs_n_in)
    clks <= sck_in ? clks + 1 : 0;
  always @(posedge sck_in)
    if (|(drv & oe_in)) err++;
  task automatic take(input int n, input bit quad, output logic [31:0] v,
                      output bit ab);
    v = 0;
    ab = 0;
    for (int i = 0; i < n && !ab; i++) begin
      @(posedge sck_in or posedge cs_n_in);
      if (cs_n_in) ab = 1;
      else v = quad ? {v[27:0], io_in} : {v[30:0], io_in[0]};
    end
  endtask : take
  task automatic stream(input logic [23:0] a);
    logic [23:0] m;
    bit          hi;
    m = 24'((8 << wrap[2:1]) - 1);
    hi = 1;
    forever begin
      @(negedge sck_in or posedge cs_n_in);
      if (cs_n_in) break;
      dout = hi ? mem[a[9:0]][7:4] : mem[a[9:0]][3:0];
      drv = 4'hf;
      if (!hi) a = (wrap[0] || cont_op == 8'he3) ? a + 1 :
                   (a & ~m) | ((a + 1) & m);
      hi = !hi;
    end
  endtask : stream
  initial begin
    logic [31:0] v;
    logic [23:0] a;
    logic [7:0]  sr;
    bit          ab;
    bit          rst_seq;
    drv = 0; dout = 0; wr_latch = 0; busy = 0; perf_mode = 0; cont = 0;
    wrap = 3'b001;
    for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'ha5;
    forever begin
      @(negedge cs_n_in);
      if (cont) op = cont_op;
      else begin take(8, 0, v, ab); op = v[7:0]; end
      case (op)
        8'hff: cont = 0;
        8'h06: wr_latch = 1;
        8'ha3: perf_mode = 1;
        8'h77: begin take(8, 1, v, ab); if (!ab) wrap = v[6:4]; end
        8'he7, 8'he3: begin
          take(6, 1, v, ab);
          a = v[23:0];
          take(2, 1, v, ab);
          if (!ab && QUAD_EN) begin
            // All ones in address and mode slot is the mode reset
            rst_seq = {a, v[7:0]} == 32'hffffffff;
            if (!rst_seq && (op == 8'he7 ? a[0] : |a[3:0])) err++;
            cont = v[5:4] == 2'b10;
            cont_op = op;
            if (op == 8'he7 && !rst_seq) take(2, 1, v, ab);
            if (!ab && !rst_seq) stream(a);
          end
        end
        8'h05: begin
          sr = {6'h0, wr_latch, busy};
          for (int i = 7; i >= 0; i--) begin
            @(negedge sck_in or posedge cs_n_in);
            if (cs_n_in) break;
            dout[1] = sr[i];
            drv = 4'b0010;
          end
        end
        8'h02: begin
          pq.delete();
          take(24, 0, v, ab);
          a = v[23:0];
          while (!ab) begin
            take(8, 0, v, ab);
            if (!ab) pq.push_back({a, v[7:0]});
            a = {a[23:8], a[7:0] + 8'h01};
          end
          if (wr_latch && pq.size() > 0 && clks % 8 == 0 &&
              a < PROT_FROM) begin
            foreach (pq[i]) mem[pq[i][17:8]] = pq[i][7:0];
            fork begin busy = 1; #(TPP); busy = 0; wr_latch = 0; end join_none
          end
        end
        default: ;
      endcase
      if (!cs_n_in) @(posedge cs_n_in);
      drv = 0;
    end
  end
endmodule : sfx_flash_model

// ---- tb_sfx_xip_host.sv ----
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_sfx_xip_host import sfx_pkg::*; ;
  logic        clock_in, rst_in, cyc, stb, we, ack, sck, cs_n;
  logic [11:0] adr;
  logic [3:0]  sel, io_o, io_oe, io_i;
  logic [31:0] wdat, rdat;
  int          n_fail, cmp_count;
  sfx_xip_host #(.HALF(4), .AW(12)) dut (.clock_in(clock_in),
    .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .sck_out(sck), .cs_n_out(cs_n), .io_out(io_o),
    .io_oe_out(io_oe), .io_in(io_i));
  sfx_flash_model #(.TPP(3000)) flash (.sck_in(sck), .cs_n_in(cs_n),
    .io_in(io_o), .oe_in(io_oe), .io_out(io_i));
  initial begin
    clock_in = 0;
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic give_verdict;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int t;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    t = 0;
    do begin @(posedge clock_in); t++; end while (ack !== 1'b1 && t < 100);
    if (t >= 100) n_fail++;
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clock_in);
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd
  // Start a command and poll until the frame has ended
  task automatic run(input logic [31:0] c);
    logic [31:0] s;
    int          t;
    wr(REG_CTRL, c);
    t = 0;
    do begin rd(REG_STAT, s); t++; end
      while (s[STAT_BUSY_BIT] !== 1'b0 && t < 2000);
    if (t >= 2000) n_fail++;
  endtask : run
  // Compare read buffer with the expected address walk; L of 0 is linear
  task automatic rdchk(input logic [23:0] s, input int n, input int l);
    logic [31:0] q;
    logic [23:0] a, m;
    a = s;
    m = 24'(l - 1);
    for (int i = 0; i < n; i++) begin
      rd(12'h400 + 12'(4 * i), q);
      chk({24'h0, q[7:0]}, {24'h0, a[7:0] ^ 8'ha5});
      a = l == 0 ? a + 1 : (a & ~m) | ((a + 1) & m);
    end
  endtask : rdchk
  initial begin
    logic [31:0] q;
    int          t;
    n_fail = 0; cmp_count = 0; cyc = 0; stb = 0; we = 0;
    adr = 0; sel = 0; wdat = 0; rst_in = 1;
    repeat (4) @(posedge clock_in);
    rst_in <= 0;
    wr(REG_CTRL, 32'(CMD_WREN)); // Early command must be refused
    rd(REG_MODE, q); chk({24'h0, q[15:8]}, 32'h10);
    t = 0;
    do begin rd(REG_STAT, q); t++; end
      while (q[STAT_INIT_BIT] !== 1'b1 && t < 1000);
    chk(32'(q[STAT_INIT_BIT]), 32'h1);
    chk(32'(q[STAT_REFUSE_BIT]), 32'h1);
    chk(32'(flash.cont), 32'h0);
    chk(32'(flash.wrap), 32'h1);
    chk(32'(flash.perf_mode), 32'h1);
    chk(32'(flash.wr_latch), 32'h0);
    wr(REG_STAT, 32'h8);
    rd(REG_STAT, q); chk(32'(q[STAT_REFUSE_BIT]), 32'h0);
    rd(12'h020, q); chk(q, 32'h0);
    // Program across the page end, first without the latch
    wr(REG_ADDR, 32'h0000fc); wr(REG_LEN, 32'd8);
    for (int i = 0; i < 8; i++) wr(12'h400 + 12'(4 * i), 32'h30 + i);
    run(32'(CMD_PROG));
    chk(32'(flash.mem[10'h0fc]), 32'(8'hfc ^ 8'ha5));
    run(32'(CMD_WREN));
    run(32'(CMD_PROG));
    run(32'(CMD_STATUS));
    rd(REG_STAT, q); chk({24'h0, q[15:8]}, 32'h03);
    repeat (700) @(posedge clock_in);
    run(32'(CMD_STATUS));
    rd(REG_STAT, q); chk({24'h0, q[15:8]}, 32'h00);
    for (int i = 0; i < 8; i++)
      chk(32'(flash.mem[{2'b00, 8'(252 + i)}]), 32'h30 + i);
    // Every wrap length, then wrap off, with reserved bits set
    wr(REG_LEN, 32'd10);
    for (int c = 0; c < 5; c++) begin
      wr(REG_MODE, {16'h0, c == 4 ? 8'h10 : {1'b1, 2'(c), 5'h0f}, 8'h00});
      run(32'(CMD_WRAP));
      chk(32'(flash.wrap), c == 4 ? 32'h1 : 32'(c * 2));
      wr(REG_ADDR, 32'h00010d);
      run(32'(CMD_WORD));
      rdchk(24'h00010c, 10, c == 4 ? 0 : 8 << c);
    end
    // Octal read entering continuous mode
    wr(REG_LEN, 32'd16); wr(REG_ADDR, 32'h123457); wr(REG_MODE, 32'h10ea);
    run(32'(CMD_OCTAL));
    rdchk(24'h123450, 16, 0);
    rd(REG_STAT, q); chk(32'(q[STAT_CONT_BIT]), 32'h1);
    chk(32'(flash.cont), 32'h1);
    wr(REG_CTRL, 32'(CMD_WREN));
    rd(REG_STAT, q); chk(32'(q[STAT_REFUSE_BIT]), 32'h1);
    wr(REG_STAT, 32'h8);
    wr(REG_ADDR, 32'h000200); wr(REG_MODE, 32'h1000);
    run(32'(CMD_OCTAL));
    rdchk(24'h000200, 16, 0);
    chk(32'(flash.clks), 32'd40);
    chk(32'(flash.cont), 32'h0);
    // Continuous reset in both widths
    for (int d = 0; d < 2; d++) begin
      wr(REG_MODE, 32'h1020);
      run(32'(CMD_OCTAL));
      chk(32'(flash.cont), 32'h1);
      run(32'(CMD_RST) | 32'(d << CTRL_DUAL_BIT));
      chk(32'(flash.cont), 32'h0);
      chk(32'(flash.clks), d == 1 ? 32'd16 : 32'd8);
      rd(REG_STAT, q); chk(32'(q[STAT_CONT_BIT]), 32'h0);
    end
    // Program into a protected page must leave memory as it was
    run(32'(CMD_WREN)); wr(REG_ADDR, 32'hf00010); wr(REG_LEN, 32'd1);
    run(32'(CMD_PROG));
    chk(32'(flash.mem[10'h010]), 32'(8'h10 ^ 8'ha5));
    chk(32'(flash.err), 32'h0);
    give_verdict();
  end
  initial begin
    #(400_000);
    n_fail++;
    give_verdict();
  end
endmodule : tb_sfx_xip_host
bind sfx_xip_host sfx_xip_monitor #(.HALF(HALF)) mon (
  .clock_in(clock_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .sck_out(sck_out),
  .cs_n_out(cs_n_out), .io_out(io_out), .io_oe_out(io_oe_out));
